// ===== bench/rxs_checker.sv
// Port-level assertions for the receive status block
`timescale 1ns/1ps
`default_nettype none
module rxs_checker
(
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [31:0] o_rdata,
	input wire logic i_mii_rx_dv,
	input wire logic i_data_underrun,
	input wire logic o_receiver_halted_event,
	input wire logic o_receive_error_flag,
	input wire logic o_status_avail
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);
	logic on_q;
	wire st_rd = i_rd && i_addr == 8'h04;
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
		if (!i_rst_n)
			on_q <= 1'b0;
		else if (i_wr && i_addr == 8'h00)
			on_q <= i_wdata[2];
	property p_rsv; st_rd |=> o_rdata[9:8] == 2'b00 && !o_rdata[0]; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved status bits set");
	property p_es; st_rd |=> o_rdata[15] == (o_rdata[11] | o_rdata[7] | o_rdata[6] | o_rdata[1]); endproperty
	a_es: assert property (p_es) else $error("error summary mismatch");
	property p_drb; st_rd |=> !(o_rdata[6] && o_rdata[2]); endproperty
	a_drb: assert property (p_drb) else $error("dribble with late collision");
	property p_typ; st_rd |=> !(o_rdata[5] && o_rdata[29:16] < 14); endproperty
	a_typ: assert property (p_typ) else $error("frame type on tiny frame");
	property p_runt; st_rd |=> o_rdata[11] == (o_rdata[29:16] != 0 && o_rdata[29:16] < 64); endproperty
	a_runt: assert property (p_runt) else $error("runt flag mismatch");
	property p_long; st_rd |=> o_rdata[7] == (o_rdata[29:16] > 1518); endproperty
	a_long: assert property (p_long) else $error("too long flag mismatch");
	property p_halt; $fell(on_q) && !i_mii_rx_dv |-> ##[1:6] o_receiver_halted_event; endproperty
	a_halt: assert property (p_halt) else $error("no halted event");
	property p_pulse; o_receiver_halted_event |=> !o_receiver_halted_event && !on_q; endproperty
	a_pulse: assert property (p_pulse) else $error("halted event too long");
	property p_dun; i_data_underrun |-> ##[1:2] o_receive_error_flag; endproperty
	a_dun: assert property (p_dun) else $error("data underrun not flagged");
	property p_sun; st_rd && !o_status_avail |-> ##[1:3] o_receive_error_flag; endproperty
	a_sun: assert property (p_sun) else $error("status underrun not flagged");
	property p_stk; o_receive_error_flag && !(i_wr && i_addr == 8'h08) |=> o_receive_error_flag; endproperty
	a_stk: assert property (p_stk) else $error("error flag dropped");
	c_halt: cover property (o_receiver_halted_event);
	c_err: cover property ($rose(o_receive_error_flag));
	c_runt: cover property (st_rd ##1 o_rdata[11]);
endmodule // rxs_checker
bind rxs_top rxs_checker u_chk (.i_ref_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_mii_rx_dv,
	.i_data_underrun, .o_receiver_halted_event, .o_receive_error_flag, .o_status_avail);
`default_nettype wire

// ===== bench/rxs_phy_model.sv
// MII frame source standing in for the PHY
`timescale 1ns/1ps
`default_nettype none
module rxs_phy_model
(
	input wire logic i_ref_clk,
	output logic o_dv,
	output logic o_er,
	output logic [3:0] o_rxd,
	output logic o_col
);
	initial
	begin
		o_dv = 0;
		o_er = 0;
		o_rxd = 4'ha;
		o_col = 0;
	end
	function automatic [31:0] f(input [31:0] c, input [7:0] b);
		int k;
		c = c ^ b;
		for (k = 0; k < 8; k++)
			c = c[0] ? (c >> 1) ^ 32'hedb8_8320 : c >> 1;
		return c;
	endfunction
	task automatic nib(input [3:0] v, input bit e, input bit c);
		@(posedge i_ref_clk);
		o_dv <= 1;
		o_rxd <= v;
		o_er <= e;
		o_col <= c;
	endtask
	// Good FCS unless bd flips bit 0 of each of the four FCS bytes; er and co fire mid-frame
	task automatic send(input [7:0] da, input [15:0] lt, input int n, input bit dr, er, co, bd);
		logic [7:0] b;
		logic [31:0] crc;
		int i;
		crc = 32'hffff_ffff;
		for (i = 0; i < 15; i++)
			nib(4'h5, 0, 0);
		nib(4'hd, 0, 0);
		for (i = 0; i < n; i++)
		begin
			if (i < n - 4)
			begin
				b = i == 0 ? da : i == 12 ? lt[15:8] : i == 13 ? lt[7:0] : i[7:0];
				crc = f(crc, b);
			end
			else
				b = ~crc[8 * (i - n + 4) +: 8] ^ {7'h0, bd};
			nib(b[3:0], er && i == 20, co && i == 70);
			nib(b[7:4], 0, 0);
		end
		if (dr)
			nib(4'ha, 0, 0);
		@(posedge i_ref_clk);
		o_dv <= 0;
		o_er <= 0;
		o_col <= 0;
		// Released bus shows the inverse so stale data never looks valid
		o_rxd <= ~o_rxd;
	endtask
endmodule // rxs_phy_model
`default_nettype wire

// ===== bench/testbench.sv
// Self-checking bench for the receive status block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam logic [13:0] WD = 14'd1600;
	logic i_ref_clk = 0, i_rst_n = 0, i_wr = 0, i_rd = 0, i_data_underrun = 0, i_status_flush = 0;
	logic [7:0] i_addr = 0;
	logic [31:0] i_wdata = 0, o_rdata, g;
	logic i_mii_rx_dv, i_mii_rx_er, i_mii_col;
	logic [3:0] i_mii_rxd;
	logic o_receiver_halted_event, o_receive_error_flag, o_status_avail;
	int bad_count = 0, cmp_count = 0, cyc = 0, halts = 0, i;
	rxs_top #(.WDOG_BYTES(WD)) dut (.i_ref_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
		.i_mii_rx_dv, .i_mii_rx_er, .i_mii_rxd, .i_mii_col, .i_data_underrun, .i_status_flush,
		.o_receiver_halted_event, .o_receive_error_flag, .o_status_avail);
	rxs_phy_model phy (.i_ref_clk, .o_dv(i_mii_rx_dv), .o_er(i_mii_rx_er), .o_rxd(i_mii_rxd), .o_col(i_mii_col));
	initial
	begin
		forever #20 i_ref_clk = ~i_ref_clk;
	end
	always @(posedge i_ref_clk)
	begin
		cyc++;
		if (o_receiver_halted_event === 1'b1)
			halts++;
		if (cyc > 40000)
		begin
			bad_count++;
			final_report;
		end
	end
	task final_report;
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task chk(input string nm, input [31:0] e, input [31:0] v);
		cmp_count++;
		if (v !== e)
		begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, v);
		end
	endtask
	task wr(input [7:0] a, input [31:0] d);
		@(posedge i_ref_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1;
		@(posedge i_ref_clk);
		i_wr <= 0;
	endtask
	task rd(input [7:0] a);
		@(posedge i_ref_clk);
		i_addr <= a;
		i_rd <= 1;
		@(posedge i_ref_clk);
		i_rd <= 0;
		#1 g = o_rdata;
	endtask
	// One frame, then queue count, and status word only when ps is set; CRC flag is masked where the host must ignore it
	task fr(input [7:0] d, input [15:0] lt, input int n, input bit dr, er, co, bd, ps);
		logic [31:0] e, m;
		e = 0;
		e[29:16] = 14'(n);
		e[11] = n < 64;
		e[10] = d[0];
		e[7] = n > 1518;
		e[6] = co;
		e[5] = lt > 1500 && n >= 14;
		e[4] = n > WD;
		e[3] = er;
		e[2] = dr && !co;
		e[1] = bd || er;
		e[15] = e[11] | e[7] | e[6] | e[1];
		m = (e[11] | e[6] | e[4]) ? 32'h2 : 32'h0;
		phy.send(d, lt, n, dr, er, co, bd);
		repeat (6) @(posedge i_ref_clk);
		rd(8'h0c);
		chk("count", {31'h0, ps}, {27'h0, g[4:0]});
		if (ps)
		begin
			rd(8'h04);
			chk("status", e & ~m, g & ~m);
		end
	endtask
	initial
	begin
		repeat (4) @(posedge i_ref_clk);
		i_rst_n <= 1;
		rd(8'h00);
		chk("ctrl reset", 32'h0, g);
		wr(8'h00, 32'h0001_0004);
		rd(8'h10);
		chk("unmapped", 32'h0, g);
		fr(8'h01, 16'h0800, 64, 0, 0, 0, 0, 1);
		fr(8'h00, 16'h0800, 63, 0, 0, 0, 0, 1);
		fr(8'h00, 16'h0800, 13, 0, 0, 0, 0, 1);
		fr(8'h02, 16'h05dc, 100, 1, 0, 0, 0, 1);
		fr(8'h02, 16'h05dd, 100, 1, 0, 1, 0, 1);
		fr(8'h02, 16'h0800, 100, 0, 1, 0, 0, 1);
		fr(8'h02, 16'h0800, 64, 0, 0, 0, 1, 1);
		fr(8'h02, 16'h0800, 1519, 0, 0, 0, 0, 1);
		fr(8'h02, 16'h0800, 1601, 0, 0, 0, 0, 1);
		wr(8'h00, 32'h4);
		fr(8'h00, 16'h0800, 63, 0, 0, 0, 0, 0);
		wr(8'h00, 32'h0);
		repeat (8) @(posedge i_ref_clk);
		chk("halt pulses", 1, halts);
		rd(8'h08);
		chk("halted", 1, g[1]);
		fr(8'h02, 16'h0800, 64, 0, 0, 0, 0, 0);
		wr(8'h00, 32'h4);
		fr(8'h02, 16'h0800, 64, 0, 0, 0, 0, 1);
		rd(8'h04);
		chk("empty read", 32'h0, g);
		rd(8'h08);
		chk("status underrun", 1, g[0]);
		wr(8'h08, 32'h1);
		rd(8'h08);
		chk("flag clear", 0, g[0]);
		@(posedge i_ref_clk);
		i_data_underrun <= 1;
		@(posedge i_ref_clk);
		i_data_underrun <= 0;
		rd(8'h08);
		chk("data underrun", 1, g[0]);
		wr(8'h08, 32'h1);
		for (i = 0; i < 17; i++)
			phy.send(8'h02, 16'h0800, 64, 0, 0, 0, 0);
		repeat (6) @(posedge i_ref_clk);
		rd(8'h08);
		chk("overrun", 1, g[0]);
		rd(8'h0c);
		chk("full count", 16, g[4:0]);
		wr(8'h00, 32'h0);
		repeat (4) @(posedge i_ref_clk);
		i_status_flush <= 1;
		@(posedge i_ref_clk);
		i_status_flush <= 0;
		repeat (2) @(posedge i_ref_clk);
		rd(8'h0c);
		chk("flushed count", 0, g[4:0]);
		wr(8'h00, 32'h4);
		fr(8'h03, 16'h0800, 64, 0, 0, 0, 0, 1);
		final_report;
	end
endmodule // testbench
`default_nettype wire

// ===== include/rxs_consts.vh
// Offsets, field positions, reset values and counts for the receive status block
`ifndef RXS_CONSTS_VH
`define RXS_CONSTS_VH

// Register word offsets (byte addresses)
`define RXS_ADDR_MAC_CTRL 8'h00
`define RXS_ADDR_STAT_PORT 8'h04
`define RXS_ADDR_ERR_FLAGS 8'h08
`define RXS_ADDR_STAT_INFO 8'h0c

// MAC control fields
`define RXS_CTRL_RX_ON_BIT 2
`define RXS_CTRL_PASS_BAD_BIT 16
`define RXS_CTRL_RESET 32'h0000_0000

// Error/flag register fields
`define RXS_FLAG_RX_ERR_BIT 0
`define RXS_FLAG_HALTED_BIT 1

// Status word fields
`define RXS_ST_LEN_HI 29
`define RXS_ST_LEN_LO 16
`define RXS_ST_ERR_SUM 15
`define RXS_ST_BCAST 13
`define RXS_ST_RUNT 11
`define RXS_ST_MCAST 10
`define RXS_ST_TOO_LONG 7
`define RXS_ST_LATE_COL 6
`define RXS_ST_ETH_TYPE 5
`define RXS_ST_WDOG 4
`define RXS_ST_MII_ERR 3
`define RXS_ST_DRIBBLE 2
`define RXS_ST_CRC_ERR 1

// Frame size limits in bytes
`define RXS_COL_WINDOW_BYTES 14'd64
`define RXS_MAX_FRAME_BYTES 14'd1518
`define RXS_WDOG_BYTES 14'd2048
`define RXS_TYPE_MIN_BYTES 14'd14
`define RXS_LEN_TYPE_MAX 16'd1500
`define RXS_MAX_COUNT 14'h3fff

// MII framing and CRC constants
`define RXS_SFD_NIBBLE 4'hd
`define RXS_CRC_INIT 32'hffff_ffff
`define RXS_CRC_POLY 32'hedb8_8320
`define RXS_CRC_RESIDUE 32'hdebb_20e3

`endif

// ===== rtl/rxs_crc32.v
// Nibble-wide Ethernet CRC-32 checker
`timescale 1ns/1ps
`default_nettype none
`include "rxs_consts.vh"
module rxs_crc32
(
	input wire i_ref_clk,
	input wire i_rst_n,
	input wire i_start,
	input wire i_nib_valid,
	input wire [3:0] i_nib,
	output wire o_crc_ok
);
	reg [31:0] crc_reg;

	// Reflected form: bits enter least significant first, as MII delivers them
	function [31:0] crc_step;
		input [31:0] crc;
		input [3:0] nib;
		integer k;
		reg [31:0] c;
		begin
			c = crc;
			for (k = 0; k < 4; k = k + 1)
			begin
				if (c[0] ^ nib[k])
					c = (c >> 1) ^ `RXS_CRC_POLY;
				else
					c = c >> 1;
			end
			crc_step = c;
		end
	endfunction

	always @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			crc_reg <= `RXS_CRC_INIT;
		else if (i_start)
			crc_reg <= `RXS_CRC_INIT;
		else if (i_nib_valid)
			crc_reg <= crc_step(crc_reg, i_nib);
	end

	assign o_crc_ok = (crc_reg == `RXS_CRC_RESIDUE);
endmodule // rxs_crc32
`default_nettype wire

// ===== rtl/rxs_stat_queue.v
// Receive status word queue with overrun and underrun detection
`timescale 1ns/1ps
`default_nettype none
module rxs_stat_queue
#(
	parameter WIDTH = 32,
	parameter AW = 4
)
(
	input wire i_ref_clk,
	input wire i_rst_n,
	input wire i_clear,
	input wire i_push,
	input wire [WIDTH-1:0] i_word,
	input wire i_pop,
	output wire [WIDTH-1:0] o_head,
	output wire [AW:0] o_count,
	output wire o_overrun,
	output wire o_underrun
);
	localparam [AW:0] DEPTH = {1'b1, {AW{1'b0}}};
	reg [WIDTH-1:0] mem [0:(1<<AW)-1];
	reg [AW:0] wr_ptr_reg;
	reg [AW:0] rd_ptr_reg;
	wire full = (o_count == DEPTH);
	wire empty = (o_count == {(AW+1){1'b0}});
	wire do_push = i_push && !full;
	wire do_pop = i_pop && !empty;

	assign o_count = wr_ptr_reg - rd_ptr_reg;
	assign o_head = mem[rd_ptr_reg[AW-1:0]];
	// A word pushed into a full queue is lost
	assign o_overrun = i_push && full;
	assign o_underrun = i_pop && empty;

	always @(posedge i_ref_clk)
	begin
		if (do_push)
			mem[wr_ptr_reg[AW-1:0]] <= i_word;
	end

	always @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			wr_ptr_reg <= {(AW+1){1'b0}};
			rd_ptr_reg <= {(AW+1){1'b0}};
		end
		else if (i_clear)
		begin
			wr_ptr_reg <= {(AW+1){1'b0}};
			rd_ptr_reg <= {(AW+1){1'b0}};
		end
		else
		begin
			if (do_push)
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (do_pop)
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
		end
	end
endmodule // rxs_stat_queue
`default_nettype wire

// ===== rtl/rxs_top.v
// Receive status word builder, receiver stop/start and receive error flag
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "rxs_consts.vh"
// Function
// - Set bit 11 when a frame ends before 64 bytes.
// - Deliver runt frames only when pass-bad-frames bit 16 is set.
// - Set bit 10 for a multicast destination address.
// - Status bits 9:8 and 0 always read zero.
// - Set bit 7 above 1518 bytes; keep receiving the whole frame.
// - Set bit 6 on a collision after the collision window.
// - Set bit 5 when length/type exceeds 1500, else clear.
// - Keep frame-type bit clear for frames under 14 bytes.
// - Set bit 4 when the receive watchdog expires.
// - Set bit 3 if receive error seen during the frame.
// - Set bit 2 for a trailing partial byte of 4 bits.
// - Never set dribbling bit when late collision bit is set.
// - Dribbling with good CRC is a valid packet.
// - Set bit 1 on CRC mismatch or any receive error.
// - Pulse the halted event once the receiver has really stopped.
// - Raise receive error on data underrun, status underrun or status overrun.
// - Receive error never stops the receiver.
// - Bit 15 is OR of bits 11, 7, 6 and 1.
// - Bits 29:16 hold the frame byte count.
module rxs_top
#(
	parameter QUEUE_AW = 4,
	parameter [13:0] WDOG_BYTES = `RXS_WDOG_BYTES
)
(
	input wire i_ref_clk,
	input wire i_rst_n,
	input wire [7:0] i_addr,
	input wire [31:0] i_wdata,
	input wire i_wr,
	input wire i_rd,
	output reg [31:0] o_rdata,
	input wire i_mii_rx_dv,
	input wire i_mii_rx_er,
	input wire [3:0] i_mii_rxd,
	input wire i_mii_col,
	input wire i_data_underrun,
	input wire i_status_flush,
	output reg o_receiver_halted_event,
	output reg o_receive_error_flag,
	output reg o_status_avail
);
	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_PREAMBLE = 3'b010;
	localparam [2:0] ST_DATA = 3'b100;

	// MII inputs come from a pin-level source; two stages before any use
	reg [6:0] mii_meta_reg;
	reg [6:0] mii_sync_reg;
	wire rx_dv = mii_sync_reg[0];
	wire rx_er = mii_sync_reg[1];
	wire [3:0] rxd = mii_sync_reg[5:2];
	wire col = mii_sync_reg[6];

	reg [31:0] mac_control_reg;
	wire receiver_on_bit = mac_control_reg[`RXS_CTRL_RX_ON_BIT];
	wire pass_bad = mac_control_reg[`RXS_CTRL_PASS_BAD_BIT];

	reg [2:0] state_reg;
	reg [2:0] state_next;
	reg halted_reg;
	reg [14:0] nib_cnt_reg;
	reg [3:0] low_nib_reg;
	reg mcast_reg;
	reg bcast_reg;
	reg late_col_reg;
	reg mii_err_reg;
	reg wdog_reg;
	reg [15:0] len_type_reg;
	reg queue_clear_reg;
	reg crc_byte_ok_reg;

	wire [13:0] byte_cnt = (nib_cnt_reg[14:1] > `RXS_MAX_COUNT) ? `RXS_MAX_COUNT : nib_cnt_reg[14:1];
	wire odd_nib = nib_cnt_reg[0];
	wire [7:0] cur_byte = {rxd, low_nib_reg};
	wire crc_ok;
	wire in_data = (state_reg == ST_DATA) && rx_dv;
	wire frame_end = (state_reg == ST_DATA) && !rx_dv;
	wire crc_good = odd_nib ? crc_byte_ok_reg : crc_ok;

	rxs_crc32 u_crc
	(
		.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n),
		.i_start(state_reg != ST_DATA),
		.i_nib_valid(in_data),
		.i_nib(rxd),
		.o_crc_ok(crc_ok)
	);

	// A dribble nibble is no part of any checked byte, so the
	// verdict at the last whole-byte boundary is the one kept
	always @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			crc_byte_ok_reg <= 1'b0;
		else if (state_reg != ST_DATA)
			crc_byte_ok_reg <= 1'b0;
		else if (rx_dv && !odd_nib)
			crc_byte_ok_reg <= crc_ok;
	end

	// Status word assembly at the end of the frame
	reg [31:0] status_word;
	reg runt;
	reg crc_err;
	always @*
	begin
		runt = (byte_cnt < `RXS_COL_WINDOW_BYTES);
		crc_err = !crc_good || mii_err_reg;
		status_word = 32'h0000_0000;
		status_word[`RXS_ST_LEN_HI:`RXS_ST_LEN_LO] = byte_cnt;
		status_word[`RXS_ST_RUNT] = runt;
		status_word[`RXS_ST_MCAST] = mcast_reg;
		status_word[`RXS_ST_BCAST] = bcast_reg;
		status_word[`RXS_ST_TOO_LONG] = (byte_cnt > `RXS_MAX_FRAME_BYTES);
		status_word[`RXS_ST_LATE_COL] = late_col_reg;
		status_word[`RXS_ST_ETH_TYPE] = (byte_cnt >= `RXS_TYPE_MIN_BYTES) && (len_type_reg > `RXS_LEN_TYPE_MAX);
		status_word[`RXS_ST_WDOG] = wdog_reg;
		status_word[`RXS_ST_MII_ERR] = mii_err_reg;
		// Nibble-wide MII can only leave 4 extra bits, which meets both thresholds
		status_word[`RXS_ST_DRIBBLE] = odd_nib && !late_col_reg;
		status_word[`RXS_ST_CRC_ERR] = crc_err;
		status_word[`RXS_ST_ERR_SUM] = runt || status_word[`RXS_ST_TOO_LONG] || late_col_reg || crc_err;
	end

	wire push = frame_end && (!runt || pass_bad);
	wire stat_rd = i_rd && (i_addr == `RXS_ADDR_STAT_PORT);
	wire [31:0] q_head;
	wire [QUEUE_AW:0] q_count;
	wire q_overrun;
	wire q_underrun;

	// Words wait here until popped; a flush empties it only while halted
	rxs_stat_queue #(.WIDTH(32), .AW(QUEUE_AW)) u_queue
	(
		.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n),
		.i_clear(queue_clear_reg),
		.i_push(push),
		.i_word(status_word),
		.i_pop(stat_rd),
		.o_head(q_head),
		.o_count(q_count),
		.o_overrun(q_overrun),
		.o_underrun(q_underrun)
	);

	always @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			mii_meta_reg <= 7'h00;
			mii_sync_reg <= 7'h00;
		end
		else
		begin
			mii_meta_reg <= {i_mii_col, i_mii_rxd, i_mii_rx_er, i_mii_rx_dv};
			mii_sync_reg <= mii_meta_reg;
		end
	end

	// A frame already under way when the receiver is turned off runs to its end
	always @*
	begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE:
				if (rx_dv && receiver_on_bit)
					state_next = ST_PREAMBLE;
			ST_PREAMBLE:
				if (!rx_dv)
					state_next = ST_IDLE;
				else if (rxd == `RXS_SFD_NIBBLE)
					state_next = ST_DATA;
			ST_DATA:
				if (!rx_dv)
					state_next = ST_IDLE;
			default:
				state_next = ST_IDLE;
		endcase
	end

	always @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			state_reg <= ST_IDLE;
			nib_cnt_reg <= 15'h0000;
			low_nib_reg <= 4'h0;
			mcast_reg <= 1'b0;
			bcast_reg <= 1'b0;
			late_col_reg <= 1'b0;
			mii_err_reg <= 1'b0;
			wdog_reg <= 1'b0;
			len_type_reg <= 16'h0000;
		end
		else
		begin
			state_reg <= state_next;
			if (state_reg != ST_DATA)
			begin
				nib_cnt_reg <= 15'h0000;
				mcast_reg <= 1'b0;
				bcast_reg <= 1'b1;
				late_col_reg <= 1'b0;
				mii_err_reg <= 1'b0;
				wdog_reg <= 1'b0;
				len_type_reg <= 16'h0000;
			end
			else if (rx_dv)
			begin
				// Counting saturates; the frame is never cut short
				if (nib_cnt_reg != 15'h7fff)
					nib_cnt_reg <= nib_cnt_reg + 15'h0001;
				if (!odd_nib)
					low_nib_reg <= rxd;
				if (nib_cnt_reg == 15'h0000)
					mcast_reg <= rxd[0];
				if (odd_nib && byte_cnt < 14'd6 && cur_byte != 8'hff)
					bcast_reg <= 1'b0;
				if (odd_nib && byte_cnt == 14'd12)
					len_type_reg[15:8] <= cur_byte;
				if (odd_nib && byte_cnt == 14'd13)
					len_type_reg[7:0] <= cur_byte;
				if (col && byte_cnt >= `RXS_COL_WINDOW_BYTES)
					late_col_reg <= 1'b1;
				if (rx_er)
					mii_err_reg <= 1'b1;
				// Watchdog only flags; the frame still runs to its end
				if (byte_cnt >= WDOG_BYTES)
					wdog_reg <= 1'b1;
			end
		end
	end

	// Halt is reported only once the receiver is off and no frame is in progress
	wire halt_now = !receiver_on_bit && (state_reg == ST_IDLE);
	reg err_set;
	always @*
	begin
		err_set = q_overrun || q_underrun || i_data_underrun;
	end

	always @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			mac_control_reg <= `RXS_CTRL_RESET;
			halted_reg <= 1'b1;
			o_receiver_halted_event <= 1'b0;
			o_receive_error_flag <= 1'b0;
			o_status_avail <= 1'b0;
			o_rdata <= 32'h0000_0000;
			queue_clear_reg <= 1'b0;
		end
		else
		begin
			if (i_wr && i_addr == `RXS_ADDR_MAC_CTRL)
				mac_control_reg <= i_wdata;
			halted_reg <= halt_now;
			o_receiver_halted_event <= halt_now && !halted_reg;
			// Set wins over a write-one-to-clear in the same cycle; reception goes on
			if (err_set)
				o_receive_error_flag <= 1'b1;
			else if (i_wr && i_addr == `RXS_ADDR_ERR_FLAGS && i_wdata[`RXS_FLAG_RX_ERR_BIT])
				o_receive_error_flag <= 1'b0;
			o_status_avail <= (q_count != {(QUEUE_AW+1){1'b0}});
			// Ignored while running, where a frame in flight would be torn
			queue_clear_reg <= i_status_flush && halted_reg;
			o_rdata <= 32'h0000_0000;
			if (i_rd)
			begin
				case (i_addr)
					`RXS_ADDR_MAC_CTRL:
						o_rdata <= mac_control_reg;
					`RXS_ADDR_STAT_PORT:
						o_rdata <= (q_count != {(QUEUE_AW+1){1'b0}}) ? q_head : 32'h0000_0000;
					`RXS_ADDR_ERR_FLAGS:
						o_rdata <= {30'h0, halted_reg, o_receive_error_flag};
					`RXS_ADDR_STAT_INFO:
						o_rdata <= {{(31-QUEUE_AW){1'b0}}, q_count};
					default:
						o_rdata <= 32'h0000_0000;
				endcase
			end
		end
	end
endmodule // rxs_top
`default_nettype wire
